// >>> common/gpr_pkg.sv
// shared constants and types for the graphics port routing ends
package gpr_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int LEN_W = 12;
    localparam int SLOT_W = 9;
    localparam int MAX_DEPTH = 256;
    localparam int ALIGN_BITS = 3;
    localparam logic [ALIGN_BITS-1:0] ALIGN_ZERO = 3'h0;
    localparam logic [ADDR_W-1:0] MAIN_TOP_DEF = 32'h4000_0000;
    localparam logic [SLOT_W-1:0] SLOT_ZERO = 9'h000;
    localparam logic [SLOT_W-1:0] SLOT_ONE = 9'h001;
    localparam logic TAG_PORT = 1'b0;
    localparam logic TAG_PCI = 1'b1;

    // bus command codes carried with each port request
    typedef enum logic [3:0] {
        GPR_CMD_IO_RD = 4'h2,
        GPR_CMD_IO_WR = 4'h3,
        GPR_CMD_MEM_RD = 4'h6,
        GPR_CMD_MEM_WR = 4'h7,
        GPR_CMD_CFG_RD = 4'ha,
        GPR_CMD_CFG_WR = 4'hb
    } gpr_cmd_e;

    // core end sequencer, gray coded along idle-mem-fwd-cpl-gfx
    typedef enum logic [2:0] {
        GPR_ST_IDLE = 3'h0,
        GPR_ST_MEM = 3'h1,
        GPR_ST_FWD = 3'h3,
        GPR_ST_CPL = 3'h2,
        GPR_ST_GFX = 3'h6
    } gpr_state_e;

    function automatic logic gpr_is_mem(input logic [3:0] cmd);
        return (cmd == GPR_CMD_MEM_RD) || (cmd == GPR_CMD_MEM_WR);
    endfunction

    function automatic logic gpr_is_write(input logic [3:0] cmd);
        return cmd[0];
    endfunction
endpackage

// >>> common/gpr_port_if.sv
// point-to-point port joining the core logic end and the graphics end
interface gpr_port_if;
    import gpr_pkg::*;
    logic req_valid;
    logic req_ready;
    logic req_pipe;
    logic [3:0] req_cmd;
    logic [ADDR_W-1:0] req_addr;
    logic [LEN_W-1:0] req_len;
    logic [DATA_W-1:0] req_wdata;
    logic cpl_valid;
    logic cpl_err;
    logic [DATA_W-1:0] cpl_rdata;
    logic [SLOT_W-1:0] pipe_slots;
    logic tgt_valid;
    logic tgt_ready;
    logic [ADDR_W-1:0] tgt_addr;
    logic [DATA_W-1:0] tgt_data;

    modport core (
        input req_valid, req_pipe, req_cmd, req_addr, req_len, req_wdata, tgt_ready,
        output req_ready, cpl_valid, cpl_err, cpl_rdata, pipe_slots, tgt_valid, tgt_addr,
        tgt_data
    );
    modport gfx (
        output req_valid, req_pipe, req_cmd, req_addr, req_len, req_wdata, tgt_ready,
        input req_ready, cpl_valid, cpl_err, cpl_rdata, pipe_slots, tgt_valid, tgt_addr,
        tgt_data
    );
endinterface

// >>> hdl/gpr_core.sv
// core logic end: routes port and pci traffic to memory, pci and the graphics target
//
// Contract
// RULE1: only main-memory reads and writes are pipelined
// RULE2: everything else runs as ordinary pci transactions
// RULE3: pipelined and pci requests interleave on one port
// RULE4: memory controller is the only pipelined target
// RULE5: core is both pci master and pci target
// RULE6: graphics end is always a full pci target
// RULE7: exactly one core and one graphics agent
// RULE8: pipelined accesses are not cache snooped
// RULE9: every pci transaction snoops the processor cache
// RULE10: writes forwarded both ways between pci and port
// RULE11: cross-bus reads are not forwarded
// RULE12: remap of pci master accesses is optional
// RULE13: unremapped pci access in range is an error
// RULE14: in-range pci access remapped or faulted, never passed
// RULE15: outstanding requests never exceed reported pipe slots
// RULE16: pipelined address and length are 8-byte multiples
module gpr_core
    import gpr_pkg::*;
#(
    parameter logic [SLOT_W-1:0] SLOTS = 9'h100,
    parameter logic [ADDR_W-1:0] MAIN_TOP = MAIN_TOP_DEF
)
(
    input wire logic clk,
    input wire logic rst_n,
    gpr_port_if.core port,
    input wire logic remap_en,
    input wire logic [ADDR_W-1:0] remap_base,
    input wire logic [ADDR_W-1:0] remap_limit,
    input wire logic [ADDR_W-1:0] remap_xlat,
    output logic mem_valid,
    input wire logic mem_ready,
    output logic mem_we,
    output logic mem_snoop,
    output logic mem_tag,
    output logic [ADDR_W-1:0] mem_addr,
    output logic [LEN_W-1:0] mem_len,
    output logic [DATA_W-1:0] mem_wdata,
    input wire logic mem_rvalid,
    input wire logic mem_rtag,
    input wire logic [DATA_W-1:0] mem_rdata,
    output logic pcio_valid,
    input wire logic pcio_ready,
    output logic [ADDR_W-1:0] pcio_addr,
    output logic [DATA_W-1:0] pcio_data,
    input wire logic pcim_valid,
    output logic pcim_ready,
    input wire logic pcim_we,
    input wire logic [ADDR_W-1:0] pcim_addr,
    input wire logic [DATA_W-1:0] pcim_data,
    output logic pcim_done,
    output logic pcim_err,
    output logic [DATA_W-1:0] pcim_rdata
);
    gpr_state_e st_q;
    logic [SLOT_W-1:0] osd_q;
    logic err_q;
    logic we_q;
    logic snoop_q;
    logic tag_q;
    logic [ADDR_W-1:0] addr_q;
    logic [LEN_W-1:0] len_q;
    logic [DATA_W-1:0] data_q;
    logic port_take;
    logic pcim_take;
    logic p_mem;
    logic p_aligned;
    logic p_main;
    logic p_room;
    logic m_in_remap;
    logic m_main;
    logic mem_fire;
    logic osd_inc;
    logic osd_dec;
    logic cpl_now;
    logic mem_idle;
    logic [SLOT_W:0] mem_osd_q;

    // address translation through the remap range
    function automatic logic [ADDR_W-1:0] remap(input logic [ADDR_W-1:0] a);
        if ((a >= remap_base) && (a <= remap_limit))
            return a - remap_base + remap_xlat;
        return a;
    endfunction

    // classification of the request on offer
    always_comb
    begin
        p_mem = gpr_is_mem(port.req_cmd);
        p_aligned = (port.req_addr[ALIGN_BITS-1:0] == ALIGN_ZERO)
            && (port.req_len[ALIGN_BITS-1:0] == ALIGN_ZERO); // RULE16
        p_main = port.req_addr < MAIN_TOP;
        p_room = osd_q < SLOTS; // RULE15
        m_in_remap = (pcim_addr >= remap_base) && (pcim_addr <= remap_limit);
        m_main = pcim_addr < MAIN_TOP;
    end

    // port has priority; a pci master is served when the port is quiet
    assign port_take = (st_q == GPR_ST_IDLE) && port.req_valid && p_room; // RULE7
    assign pcim_take = (st_q == GPR_ST_IDLE) && !port.req_valid && pcim_valid;
    assign port.req_ready = port_take; // RULE3
    assign pcim_ready = pcim_take; // RULE5
    assign port.pipe_slots = SLOTS; // RULE15

    assign mem_valid = (st_q == GPR_ST_MEM);
    assign mem_fire = mem_valid && mem_ready;
    assign pcio_valid = (st_q == GPR_ST_FWD);
    assign port.tgt_valid = (st_q == GPR_ST_GFX);
    assign osd_inc = mem_fire && (tag_q == TAG_PORT);
    assign osd_dec = mem_rvalid && (mem_rtag == TAG_PORT);
    // local completions wait for memory replies so answers stay in order
    assign mem_idle = (mem_osd_q == '0);
    assign cpl_now = (st_q == GPR_ST_CPL) && mem_idle;

    // sequencer
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            st_q <= GPR_ST_IDLE;
        else
        begin
            case (st_q)
                GPR_ST_IDLE:
                begin
                    if (port_take)
                    begin
                        if (port.req_pipe)
                            st_q <= (p_mem && p_aligned && p_main) // RULE1
                                ? GPR_ST_MEM : GPR_ST_CPL;
                        else if (p_mem && p_main)
                            st_q <= GPR_ST_MEM;
                        else if (gpr_is_write(port.req_cmd))
                            st_q <= GPR_ST_FWD; // RULE10
                        else
                            st_q <= GPR_ST_CPL; // RULE11
                    end
                    else if (pcim_take)
                    begin
                        if (m_in_remap && !remap_en)
                            st_q <= GPR_ST_CPL; // RULE13
                        else if (m_in_remap || m_main)
                            st_q <= GPR_ST_MEM; // RULE12
                        else if (pcim_we)
                            st_q <= GPR_ST_GFX; // RULE10
                        else
                            st_q <= GPR_ST_CPL; // RULE11
                    end
                end
                GPR_ST_MEM:
                    if (mem_ready)
                        st_q <= GPR_ST_IDLE; // RULE4
                GPR_ST_FWD:
                    if (pcio_ready)
                        st_q <= GPR_ST_CPL; // RULE2
                GPR_ST_GFX:
                    if (port.tgt_ready)
                        st_q <= GPR_ST_CPL; // RULE6
                GPR_ST_CPL:
                    if (mem_idle)
                        st_q <= GPR_ST_IDLE;
                default:
                    st_q <= GPR_ST_IDLE;
            endcase
        end
    end

    // latched request fields and routing attributes
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            err_q <= 1'b0;
            we_q <= 1'b0;
            snoop_q <= 1'b0;
            tag_q <= TAG_PORT;
            addr_q <= '0;
            len_q <= '0;
            data_q <= '0;
        end
        else if (port_take)
        begin
            tag_q <= TAG_PORT;
            we_q <= gpr_is_write(port.req_cmd);
            snoop_q <= !port.req_pipe; // RULE8 RULE9
            addr_q <= remap(port.req_addr);
            len_q <= port.req_len;
            data_q <= port.req_wdata;
            err_q <= port.req_pipe ? !(p_mem && p_aligned && p_main)
                : !((p_mem && p_main) || gpr_is_write(port.req_cmd));
        end
        else if (pcim_take)
        begin
            tag_q <= TAG_PCI;
            we_q <= pcim_we;
            snoop_q <= 1'b1; // RULE9
            addr_q <= remap_en ? remap(pcim_addr) : pcim_addr; // RULE14
            len_q <= LEN_W'(DATA_W / 8);
            data_q <= pcim_data;
            err_q <= m_in_remap ? !remap_en : !(m_main || pcim_we); // RULE13 RULE14
        end
    end

    assign mem_we = we_q;
    assign mem_snoop = snoop_q;
    assign mem_tag = tag_q;
    assign mem_addr = addr_q;
    assign mem_len = len_q;
    assign mem_wdata = data_q;
    assign pcio_addr = addr_q;
    assign pcio_data = data_q;
    assign port.tgt_addr = addr_q;
    assign port.tgt_data = data_q;

    // port requests in flight at the memory controller
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            osd_q <= SLOT_ZERO;
        else if (osd_inc && !osd_dec)
            osd_q <= osd_q + SLOT_ONE; // RULE15
        else if (osd_dec && !osd_inc)
            osd_q <= osd_q - SLOT_ONE;
    end

    // every memory access in flight, either tag; local answers wait for zero
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            mem_osd_q <= '0;
        else if (mem_fire && !mem_rvalid)
            mem_osd_q <= mem_osd_q + {1'b0, SLOT_ONE};
        else if (mem_rvalid && !mem_fire)
            mem_osd_q <= mem_osd_q - {1'b0, SLOT_ONE};
    end

    // completions back to the graphics end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            port.cpl_valid <= 1'b0;
            port.cpl_err <= 1'b0;
            port.cpl_rdata <= '0;
        end
        else
        begin
            port.cpl_valid <= osd_dec || (cpl_now && tag_q == TAG_PORT);
            port.cpl_err <= !osd_dec && err_q;
            port.cpl_rdata <= osd_dec ? mem_rdata : '0;
        end
    end

    // completions back to the pci master
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pcim_done <= 1'b0;
            pcim_err <= 1'b0;
            pcim_rdata <= '0;
        end
        else
        begin
            pcim_done <= (mem_rvalid && mem_rtag == TAG_PCI)
                || (cpl_now && tag_q == TAG_PCI);
            pcim_err <= !(mem_rvalid && mem_rtag == TAG_PCI) && err_q; // RULE13
            pcim_rdata <= (mem_rvalid && mem_rtag == TAG_PCI) ? mem_rdata : '0;
        end
    end
endmodule

// >>> hdl/gpr_gfx.sv
// graphics end: single port master that also serves as the port's pci target
module gpr_gfx
    import gpr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    gpr_port_if.gfx port,
    input wire logic usr_valid,
    output logic usr_ready,
    output logic usr_reject,
    input wire logic usr_pipe,
    input wire logic [3:0] usr_cmd,
    input wire logic [ADDR_W-1:0] usr_addr,
    input wire logic [LEN_W-1:0] usr_len,
    input wire logic [DATA_W-1:0] usr_wdata,
    output logic usr_cpl_valid,
    output logic usr_cpl_err,
    output logic [DATA_W-1:0] usr_cpl_data,
    output logic lcl_we,
    output logic [ADDR_W-1:0] lcl_addr,
    output logic [DATA_W-1:0] lcl_data
);
    logic [SLOT_W-1:0] osd_q;
    logic busy_q;
    logic bad;
    logic take;
    logic sent;

    // pipelined requests must be aligned memory reads or writes; the main-memory address check is left to the core
    assign bad = usr_pipe && (!gpr_is_mem(usr_cmd)
        || usr_addr[ALIGN_BITS-1:0] != ALIGN_ZERO
        || usr_len[ALIGN_BITS-1:0] != ALIGN_ZERO); // RULE1 RULE16
    // never more requests in flight than the core's pipe slots
    assign usr_ready = !busy_q && (osd_q < port.pipe_slots); // RULE15
    assign take = usr_valid && usr_ready && !bad;
    assign sent = port.req_valid && port.req_ready;
    assign usr_reject = usr_valid && usr_ready && bad;

    // request holding register, held until the core takes it
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy_q <= 1'b0;
            port.req_valid <= 1'b0;
            port.req_pipe <= 1'b0;
            port.req_cmd <= '0;
            port.req_addr <= '0;
            port.req_len <= '0;
            port.req_wdata <= '0;
        end
        else if (take)
        begin
            busy_q <= 1'b1;
            port.req_valid <= 1'b1;
            port.req_pipe <= usr_pipe;
            port.req_cmd <= usr_cmd;
            port.req_addr <= usr_addr;
            port.req_len <= usr_len;
            port.req_wdata <= usr_wdata;
        end
        else if (sent)
        begin
            busy_q <= 1'b0;
            port.req_valid <= 1'b0;
        end
    end

    // requests sent and not yet completed
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            osd_q <= SLOT_ZERO;
        else if (sent && !port.cpl_valid)
            osd_q <= osd_q + SLOT_ONE; // RULE15
        else if (port.cpl_valid && !sent)
            osd_q <= osd_q - SLOT_ONE;
    end

    // completions, in request order
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            usr_cpl_valid <= 1'b0;
            usr_cpl_err <= 1'b0;
            usr_cpl_data <= '0;
        end
        else
        begin
            usr_cpl_valid <= port.cpl_valid;
            usr_cpl_err <= port.cpl_err; // RULE8
            usr_cpl_data <= port.cpl_rdata;
        end
    end

    // pci target: every forwarded write is taken at once
    assign port.tgt_ready = 1'b1; // RULE6
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lcl_we <= 1'b0;
            lcl_addr <= '0;
            lcl_data <= '0;
        end
        else
        begin
            lcl_we <= port.tgt_valid; // RULE10
            lcl_addr <= port.tgt_addr;
            lcl_data <= port.tgt_data;
        end
    end
endmodule

// >>> verification/gpr_port_properties.sv
// concurrent checks on the port joining the core and graphics ends
module gpr_port_properties
    import gpr_pkg::*;
#(
    parameter logic [ADDR_W-1:0] MAIN_TOP = MAIN_TOP_DEF
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic req_pipe,
    input wire logic [3:0] req_cmd,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [LEN_W-1:0] req_len,
    input wire logic cpl_valid,
    input wire logic cpl_err,
    input wire logic [SLOT_W-1:0] pipe_slots,
    input wire logic tgt_valid,
    input wire logic tgt_ready
);
    logic take;
    logic far;
    logic [SLOT_W:0] cnt_q;
    // a request is taken; far means it is not a main-memory access
    assign take = req_valid && req_ready;
    assign far = req_cmd[3:1] != 3'h3 || req_addr >= MAIN_TOP;
    // requests taken but not yet completed
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            cnt_q <= '0;
        else
            cnt_q <= cnt_q + (SLOT_W+1)'(take) - (SLOT_W+1)'(cpl_valid);
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_pipe_mem_only: assert property (take && req_pipe |-> req_cmd[3:1] == 3'h3)
        else $error("pipelined request with a non-memory command");
    a_pipe_aligned: assert property (take && req_pipe |-> req_addr[2:0] == 3'h0 && req_len[2:0] == 3'h0)
        else $error("pipelined request not on an 8-byte grid");
    a_slot_bound: assert property (cnt_q <= pipe_slots && pipe_slots <= MAX_DEPTH)
        else $error("outstanding requests beyond the pipe slots");
    a_slots_fixed: assert property ($stable(pipe_slots))
        else $error("pipe slot count changed");
    a_req_held: assert property (req_valid && !req_ready |=> req_valid && $stable(req_addr) && $stable(req_cmd) && $stable(req_pipe))
        else $error("request dropped or changed before taken");
    a_take_gap: assert property (take |=> !req_ready)
        else $error("two requests taken on adjacent cycles");
    a_tgt_accept: assert property (tgt_valid |-> tgt_ready)
        else $error("graphics end refused a forwarded write");
    a_cpl_owed: assert property (cpl_valid |-> cnt_q != 0)
        else $error("completion with nothing outstanding");
    a_far_read_err: assert property (take && !req_pipe && !req_cmd[0] && far && cnt_q == 0 |-> ##[2:20] (cpl_valid && cpl_err))
        else $error("cross read not refused in time");
    a_fwd_write_ok: assert property (take && !req_pipe && req_cmd[0] && far && cnt_q == 0 |-> ##[3:60] (cpl_valid && !cpl_err))
        else $error("forwarded write not completed in time");
    c_pipe: cover property (take && req_pipe);
    c_full: cover property (cnt_q == pipe_slots);
    c_tgt: cover property (tgt_valid);
    c_err: cover property (cpl_valid && cpl_err);
endmodule

// >>> verification/tb_graphics_port_core_routing.sv
// bench joining the core and graphics ends with memory and pci models
module tb_graphics_port_core_routing;
    import gpr_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_n = 0;
    logic remap_en, mem_valid, mem_ready, mem_we, mem_snoop, mem_tag, mem_rvalid, mem_rtag;
    logic pcio_valid, pcio_ready, pcim_valid, pcim_ready, pcim_we, pcim_done, pcim_err;
    logic usr_valid, usr_ready, usr_reject, usr_pipe, usr_cpl_valid, usr_cpl_err, lcl_we;
    logic [3:0] usr_cmd;
    logic [LEN_W-1:0] mem_len, usr_len;
    logic [31:0] remap_base, remap_limit, remap_xlat, mem_addr, mem_wdata, mem_rdata;
    logic [31:0] pcio_addr, pcio_data, pcim_addr, pcim_data, pcim_rdata, usr_addr;
    logic [31:0] usr_wdata, usr_cpl_data, lcl_addr, lcl_data;
    logic [33:0] cq[$], pq[$], mq[$], oq[$], lq[$], rq[$], r;
    logic [3:0] cmds [6] = '{4'h2, 4'h3, 4'h6, 4'h7, 4'ha, 4'hb};
    int miscompares = 0, tests_run = 0, cyc = 0;
    gpr_port_if gp();
    gpr_core #(.SLOTS(9'h004)) i_gpr_core (.port(gp.core), .*);
    gpr_gfx i_gpr_gfx (.port(gp.gfx), .*);
    gpr_port_properties i_props (.clk(clk), .rst_n(rst_n), .req_valid(gp.req_valid),
        .req_ready(gp.req_ready), .req_pipe(gp.req_pipe), .req_cmd(gp.req_cmd),
        .req_addr(gp.req_addr), .req_len(gp.req_len), .cpl_valid(gp.cpl_valid),
        .cpl_err(gp.cpl_err), .pipe_slots(gp.pipe_slots), .tgt_valid(gp.tgt_valid),
        .tgt_ready(gp.tgt_ready));
    always #2 clk = ~clk;
    task automatic end_sim;
        $display("tests_run %0d miscompares %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk_val(input logic [33:0] g, input logic [33:0] e);
        tests_run++;
        if (g !== e)
        begin
            miscompares++;
            $display("mismatch at %0t got %h exp %h", $time, g, e);
        end
    endtask
    // completion note: data-check flag, error, data
    task automatic chk_cpl(input logic err, input logic [31:0] d, input logic [33:0] e);
        chk_val({e[33], err, e[33] ? d : e[31:0]}, e);
    endtask
    // graphics user request with its expected route and answer
    task automatic send(input logic p, input logic [3:0] c, input logic [31:0] a,
        input logic [11:0] n);
        logic mem, bad;
        mem = c[3:1] == 3'h3;
        bad = p && (!mem || a[2:0] != 3'h0 || n[2:0] != 3'h0);
        @(negedge clk);
        {usr_valid, usr_pipe, usr_cmd, usr_addr, usr_len} = {1'b1, p, c, a, n};
        usr_wdata = $urandom;
        #1;
        while (!usr_ready)
        begin
            @(negedge clk);
            #1;
        end
        chk_val({33'h0, usr_reject}, {33'h0, bad});
        @(negedge clk);
        usr_valid = 0;
        if (!bad && mem && a < MAIN_TOP_DEF)
        begin
            mq.push_back({c[0], !p, a});
            cq.push_back({!c[0], 1'b0, c[0] ? 32'h0 : ~a});
        end
        else if (!bad)
        begin
            if (c[0] && !p)
                oq.push_back({2'h0, a});
            cq.push_back({1'b1, !c[0] || p, 32'h0});
        end
    endtask
    // pci master access with its expected route and answer
    task automatic pm(input logic w, input logic [31:0] a);
        logic inr;
        logic [31:0] t;
        inr = a >= remap_base && a <= remap_limit;
        t = inr ? a - remap_base + remap_xlat : a;
        @(negedge clk);
        {pcim_valid, pcim_we, pcim_addr} = {1'b1, w, a};
        pcim_data = $urandom;
        #1;
        while (!pcim_ready)
        begin
            @(negedge clk);
            #1;
        end
        @(negedge clk);
        pcim_valid = 0;
        if (inr && !remap_en || t >= MAIN_TOP_DEF && !w)
            pq.push_back({1'b0, 1'b1, 32'h0});
        else if (t < MAIN_TOP_DEF)
        begin
            mq.push_back({w, 1'b1, t});
            pq.push_back({!w, 1'b0, w ? 32'h0 : ~t});
        end
        else
        begin
            lq.push_back({2'h0, t});
            pq.push_back({1'b0, 1'b0, 32'h0});
        end
    endtask
    // memory model: random stalls, replies in request order
    always @(posedge clk)
        if (mem_valid && mem_ready)
        begin
            chk_val({mem_we, mem_snoop, mem_addr}, mq.pop_front());
            rq.push_back({mem_we, mem_tag, mem_addr});
        end
    // reply and ready drive at the falling edge
    always @(negedge clk)
    begin
        mem_ready <= 1'($urandom);
        pcio_ready <= 1'($urandom);
        if (rq.size() != 0 && 1'($urandom))
        begin
            r = rq.pop_front();
            mem_rvalid <= 1;
            mem_rtag <= r[32];
            mem_rdata <= r[33] ? 32'h0 : ~r[31:0];
        end
        else
            mem_rvalid <= 0;
    end
    // result watcher and cycle limit
    always @(posedge clk)
    begin
        if (usr_cpl_valid)
            chk_cpl(usr_cpl_err, usr_cpl_data, cq.pop_front());
        if (pcim_done)
            chk_cpl(pcim_err, pcim_rdata, pq.pop_front());
        if (pcio_valid && pcio_ready)
            chk_val({2'h0, pcio_addr}, oq.pop_front());
        if (lcl_we)
            chk_val({2'h0, lcl_addr}, lq.pop_front());
        cyc++;
        if (cyc > 20000)
        begin
            miscompares++;
            end_sim;
        end
    end
    // main sequence
    initial
    begin
        {usr_valid, usr_pipe, pcim_valid, pcim_we, remap_en, mem_ready, mem_rvalid} = '0;
        {mem_rtag, pcio_ready, usr_cmd, usr_addr, usr_len, usr_wdata, pcim_addr} = '0;
        {pcim_data, mem_rdata} = '0;
        {remap_base, remap_limit, remap_xlat} = {32'h8000_0000, 32'h80ff_ffff, 32'h0100_0000};
        void'($urandom(32'h1e65));
        repeat (3) @(negedge clk);
        rst_n = 1;
        repeat (20) send(1, {3'h3, 1'($urandom)}, $urandom & 32'h3fff_fff8,
            12'(8 * $urandom_range(8, 1)));
        $display("test pipelined memory done");
        foreach (cmds[i])
        begin
            send(1, cmds[i], 32'h100, 12'h8);
            send(1, cmds[i], 32'h104, 12'h8);
            send(1, cmds[i], 32'h100, 12'h4);
            send(0, cmds[i], 32'h200, 12'h4);
            send(0, cmds[i], 32'h5000_0000, 12'h4);
        end
        $display("test command table done");
        for (int e = 0; e < 2; e++)
        begin
            remap_en = 1'(e);
            for (int w = 0; w < 2; w++)
            begin
                pm(1'(w), 32'h8000_0040);
                pm(1'(w), 32'h0000_0400);
                pm(1'(w), 32'h9000_0000);
            end
        end
        $display("test pci master done");
        repeat (12)
        begin
            send(1'($urandom), cmds[$urandom_range(5, 0)],
                1'($urandom) ? 32'h5000_0000 : $urandom & 32'h3fff_fff8, 12'h10);
            pm(1'($urandom), 1'($urandom) ? 32'h9000_0010 : 32'h0000_0800);
        end
        for (int i = 0; i < 500 && cq.size() + pq.size() + mq.size() + oq.size() + lq.size() != 0; i++)
            @(posedge clk);
        chk_val(34'(cq.size() + pq.size() + mq.size() + oq.size() + lq.size()), 34'h0);
        $display("test interleave done");
        end_sim;
    end
endmodule
